/* File: dap_defines.svh */
/*
 register offsets, field layout, reset values and frame timing counts
 for the pass-through digital audio transmitter; included by bare name
*/
`ifndef DAP_DEFINES_SVH
`define DAP_DEFINES_SVH
// register byte offsets
`define DAP_CTRL_OFS 8'h00
`define DAP_CFG_OFS 8'h04
`define DAP_STAT_OFS 8'h08
// register widths and reset values
`define DAP_CTRL_W 13
`define DAP_CFG_W 11
`define DAP_CTRL_RST 13'h0002
`define DAP_CFG_RST 11'h204
// status fields
`define DAP_STAT_STALE 0
`define DAP_STAT_KEEP 1
`define DAP_STAT_FRAME_LSB 8
// frame timing
`define DAP_BLOCK_FRAMES 8'd192
`define DAP_LAST_FRAME 8'd191
`define DAP_LAST_SLOT 5'd31
`define DAP_VALID_SLOT 5'd28
`define DAP_USER_SLOT 5'd29
`define DAP_STATUS_SLOT 5'd30
`define DAP_LAST_AUDIO_SLOT 5'd27
`define DAP_FIRST_CODED_SLOT 5'd4
`define DAP_RATE_CS_FIRST 8'd24
// preamble patterns, first state in the top bit, for a low previous state
`define DAP_PRE_B 8'he8
`define DAP_PRE_M 8'he2
`define DAP_PRE_W 8'he4
// rate nibbles carried in channel status bits 24..27, lsb first
`define DAP_CS_32K 4'hc
`define DAP_CS_44K1 4'h0
`define DAP_CS_48K 4'h4
`define DAP_CS_88K2 4'h1
`define DAP_CS_96K 4'h5
`define DAP_CS_176K4 4'h3
`define DAP_CS_192K 4'h7
`endif

/* File: dap_pkg.sv */
/*
 types shared by the transmitter and its line coder
 assumes dap_defines.svh for the numbers
*/
package dap_pkg;
   typedef struct packed {
      logic second_empty;
      logic [2:0] clk_div;
      logic bit_clock_internal;
      logic frame_clock_polarity;
      logic frame_clock_source_select;
      logic port1_double_rate;
      logic port0_double_rate;
      logic source_alt_bus;
      logic keepalive_enable_bit;
      logic transmitter_power_down;
      logic digital_output_enable;
   } dap_ctrl_type;
   typedef struct packed {
      logic [2:0] rate_code;
      logic [1:0] tx_sample_resolution;
      logic [1:0] rx_slot_resolution;
      logic [1:0] chan_b_slot_select;
      logic [1:0] chan_a_slot_select;
   } dap_cfg_type;
   typedef struct packed {
      logic [31:0] left;
      logic [31:0] right;
   } dap_pair_type;
   typedef enum logic [2:0] {
      DAP_OFF = 3'b001,
      DAP_ALIGN = 3'b010,
      DAP_RUN = 3'b100
   } dap_state_type;
endpackage : dap_pkg

/* File: dap_bmc_coder.sv */
/*
 biphase mark line coder with preamble insertion
 assumes one tick per half-bit state from the transmitter
*/
`timescale 1ns/100ps
module dap_bmc_coder
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // symbol stream
   input wire logic enable,
   input wire logic tick,
   input wire logic preamble,
   input wire logic [7:0] pre_pattern,
   input wire logic [2:0] pre_idx,
   input wire logic half,
   input wire logic data_bit,
   // line
   output logic line
);
   import dap_pkg::*;
   logic ref_level;

   // preambles break the coding on purpose so a receiver can find them
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         line <= 1'b0;
         ref_level <= 1'b0;
      end
      else if (!enable)
         line <= 1'b0;
      else if (tick)
      begin
         if (preamble)
         begin
            if (pre_idx == 3'h0)
            begin
               ref_level <= line;
               line <= pre_pattern[7] ^ line; // [RULE17]
            end
            else
               line <= pre_pattern[3'h7 - pre_idx] ^ ref_level; // [RULE17]
         end
         else if (!half)
            line <= ~line; // [RULE18]
         else if (data_bit)
            line <= ~line; // [RULE18]
      end
   end
endmodule : dap_bmc_coder

/* File: dap_spdif_tx.sv */
/*
 pass-through digital audio transmitter with an ahb-lite register slave
 assumes receive port and pin inputs are synchronous to sys_clk and that
 software sets everything up before enabling the output
*/
`timescale 1ns/100ps
`include "dap_defines.svh"
// How it works
// [RULE1] resends two samples of 16, 20, 24 or 32 bits per resolution settings
// [RULE2] rate code picks 32 to 192 kHz, sent in channel status
// [RULE3] samples pass untouched, no decoding, no rate conversion
// [RULE4] one sample per frame; missing samples flagged, no null handling
// [RULE5] first port: channel a and b selectors pick slots 0 to 3
// [RULE6] second port double rate: take second port, channel 0 left, 1 right
// [RULE7] alternative bus samples are retimed through a holding register
// [RULE8] frame clock source select and polarity invert
// [RULE9] software writes all settings before powering the paths up
// [RULE10] half-bit tick at 128 times the rate, from pin or divider
// [RULE11] with converters running, outside supplies the clock on the pin
// [RULE12] software sets divider for the transmitter rate, not frame clock
// [RULE13] divider codes give ratios 1, 2, 3, 4 and 8
// [RULE14] first subframe preamble m, b every 192 frames; second w
// [RULE15] empty second subframe sends validity slot 28 high
// [RULE16] every subframe has slots 0 to 31
// [RULE17] slots 4 to 31 biphase mark coded, preambles exempt
// [RULE18] each bit two states: first inverts, second inverts on one
// [RULE19] keep-alive sends clocking and status without audio bits
// [RULE20] output enable and power down decide the pin state
// [RULE21] keep-alive enable bit is stored but does nothing
module dap_spdif_tx
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // clock pins
   input wire logic serial_bit_clock_in,
   input wire logic bus_clock_in,
   input wire logic frame_clock_in,
   // first receive port, four slots
   input wire logic [3:0][31:0] port0_slots,
   input wire logic port0_valid,
   // second receive port, two channels
   input wire dap_pkg::dap_pair_type port1_pair,
   input wire logic port1_valid,
   // alternative audio bus
   input wire dap_pkg::dap_pair_type alt_pair,
   input wire logic alt_valid,
   // coded output
   output logic spdif_out
);
   import dap_pkg::*;

   dap_ctrl_type ctrl;
   dap_cfg_type cfg;
   dap_state_type state;
   dap_pair_type hold0, hold1, hold_alt, cur, next_pair;
   logic wr_pend, stale, new_flag, latch_now, go, tick, ref_edge, pin, pin_q;
   logic fc_q, fc_edge, half, sub, par, cur_bit, keep, novalid, preamble;
   logic [7:0] wr_addr, frame, pre_pattern;
   logic [4:0] slot;
   logic [2:0] div_cnt, ratio_m1;
   logic [1:0] eff_res;
   logic [3:0] cs_nib;
   logic [31:0] dat, mask;

   // zero-wait slave; read data are prepared during the address phase
   wire addr_ok = hsel && htrans[1] && hready;
   wire wr_stat = wr_pend && (wr_addr == `DAP_STAT_OFS);

   // bus slave: capture writes, answer reads from a register
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         hrdata <= 32'h0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend <= addr_ok && hwrite;
         wr_addr <= haddr[7:0];
         if (addr_ok && !hwrite)
         begin
            unique case (haddr[7:0])
               `DAP_CTRL_OFS: hrdata <= 32'(ctrl); // [RULE21]
               `DAP_CFG_OFS: hrdata <= 32'(cfg);
               `DAP_STAT_OFS: hrdata <= {16'h0, frame, 6'h0, keep, stale};
               default: hrdata <= 32'h0;
            endcase
         end
      end
   end

   // control and configuration registers
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         ctrl <= dap_ctrl_type'(`DAP_CTRL_RST);
         cfg <= dap_cfg_type'(`DAP_CFG_RST);
      end
      else if (wr_pend && wr_addr == `DAP_CTRL_OFS)
         ctrl <= dap_ctrl_type'(hwdata[`DAP_CTRL_W-1:0]);
      else if (wr_pend && wr_addr == `DAP_CFG_OFS)
         cfg <= dap_cfg_type'(hwdata[`DAP_CFG_W-1:0]);
   end

   // divider ratio minus one; reserved codes fall back to one
   always_comb
   begin
      unique case (ctrl.clk_div)
         3'h1: ratio_m1 = 3'h1; // [RULE13]
         3'h2: ratio_m1 = 3'h2; // [RULE13]
         3'h3: ratio_m1 = 3'h3; // [RULE13]
         3'h4: ratio_m1 = 3'h7; // [RULE13]
         default: ratio_m1 = 3'h0; // [RULE13]
      endcase
   end

   // reference is a pin edge or every system clock; software owns the ratio
   assign pin = ctrl.source_alt_bus ? bus_clock_in : serial_bit_clock_in; // [RULE11]
   assign ref_edge = ctrl.bit_clock_internal || (pin && !pin_q); // [RULE10]

   // half-bit tick generator
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         pin_q <= 1'b0;
         div_cnt <= 3'h0;
         tick <= 1'b0;
      end
      else
      begin
         pin_q <= pin;
         tick <= 1'b0;
         if (ref_edge)
         begin
            if (div_cnt >= ratio_m1)
            begin
               div_cnt <= 3'h0;
               tick <= 1'b1; // [RULE10] [RULE12]
            end
            else
               div_cnt <= div_cnt + 3'h1;
         end
      end
   end

   // frame clock edge, after the polarity choice
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
         fc_q <= 1'b0;
      else
         fc_q <= frame_clock_in ^ ctrl.frame_clock_polarity; // [RULE8]
   end
   assign fc_edge = (frame_clock_in ^ ctrl.frame_clock_polarity) && !fc_q;
   // external frame clock only aligns the start; later edges are not tracked
   assign go = ctrl.frame_clock_source_select ? fc_edge : 1'b1; // [RULE8]

   // transmitter sequencing
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
         state <= DAP_OFF;
      else if (!ctrl.digital_output_enable)
         state <= DAP_OFF; // [RULE20]
      else
      begin
         unique case (state)
            DAP_OFF: state <= DAP_ALIGN;
            DAP_ALIGN: state <= go ? DAP_RUN : DAP_ALIGN;
            DAP_RUN: state <= DAP_RUN;
            default: state <= DAP_OFF;
         endcase
      end
   end

   assign latch_now = (state == DAP_ALIGN && go && ctrl.digital_output_enable) ||
      (state == DAP_RUN && tick && half && sub && slot == `DAP_LAST_SLOT);

   // frame position: half-bit, slot, subframe and block index
   always_ff @(posedge sys_clk)
   begin
      if (!resetn || state != DAP_RUN)
      begin
         half <= 1'b0;
         slot <= 5'h0;
         sub <= 1'b0;
         frame <= 8'h0;
      end
      else if (tick)
      begin
         half <= ~half;
         if (half)
         begin
            slot <= slot + 5'h1; // [RULE16]
            if (slot == `DAP_LAST_SLOT)
            begin
               sub <= ~sub;
               if (sub)
                  frame <= (frame == `DAP_LAST_FRAME) ? 8'h0 : frame + 8'h1; // [RULE14]
            end
         end
      end
   end

   // input holding registers; the alternative bus is retimed here
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         hold0 <= '0;
         hold1 <= '0;
         hold_alt <= '0;
      end
      else
      begin
         if (port0_valid)
         begin
            // double rate on the first port leaves only slots 0 and 1
            hold0.left <= port0_slots[ctrl.port0_double_rate ?
               {1'b0, cfg.chan_a_slot_select[0]} : cfg.chan_a_slot_select]; // [RULE5]
            hold0.right <= port0_slots[ctrl.port0_double_rate ?
               {1'b0, cfg.chan_b_slot_select[0]} : cfg.chan_b_slot_select]; // [RULE5]
         end
         if (port1_valid)
            hold1 <= port1_pair; // [RULE6]
         if (alt_valid)
            hold_alt <= alt_pair; // [RULE7]
      end
   end

   // width is the narrower of the two resolution settings
   assign eff_res = (cfg.rx_slot_resolution < cfg.tx_sample_resolution) ?
      cfg.rx_slot_resolution : cfg.tx_sample_resolution;

   // source choice and truncation; the bits themselves are never altered
   always_comb
   begin
      unique case (eff_res)
         2'h0: mask = 32'hffff0000; // [RULE1]
         2'h1: mask = 32'hfffff000; // [RULE1]
         2'h2: mask = 32'hffffff00; // [RULE1]
         default: mask = 32'hffffffff; // [RULE1]
      endcase
      if (ctrl.port1_double_rate)
         next_pair = hold1; // [RULE6]
      else if (ctrl.source_alt_bus)
         next_pair = hold_alt; // [RULE7]
      else
         next_pair = hold0; // [RULE5]
      next_pair.left = next_pair.left & mask; // [RULE3]
      next_pair.right = next_pair.right & mask; // [RULE3]
   end

   // frame latch and new-sample tracking
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         cur <= '0;
         new_flag <= 1'b0;
      end
      else
      begin
         if (latch_now)
            cur <= next_pair; // [RULE3]
         if (ctrl.port1_double_rate ? port1_valid :
             ctrl.source_alt_bus ? alt_valid : port0_valid)
            new_flag <= 1'b1;
         else if (latch_now)
            new_flag <= 1'b0;
      end
   end

   // sticky stale flag; a new set beats a software clear in the same cycle
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
         stale <= 1'b0;
      else if (latch_now && state == DAP_RUN && !new_flag)
         stale <= 1'b1; // [RULE4]
      else if (wr_stat && hwdata[`DAP_STAT_STALE])
         stale <= 1'b0;
   end

   // rate nibble for channel status bits 24..27
   always_comb
   begin
      unique case (cfg.rate_code)
         3'h0: cs_nib = `DAP_CS_32K; // [RULE2]
         3'h1: cs_nib = `DAP_CS_44K1; // [RULE2]
         3'h2: cs_nib = `DAP_CS_48K; // [RULE2]
         3'h3: cs_nib = `DAP_CS_88K2; // [RULE2]
         3'h4: cs_nib = `DAP_CS_96K; // [RULE2]
         3'h5: cs_nib = `DAP_CS_176K4; // [RULE2]
         default: cs_nib = `DAP_CS_192K; // [RULE2]
      endcase
   end

   // keep-alive while powered down with the output still enabled
   assign keep = ctrl.digital_output_enable && ctrl.transmitter_power_down; // [RULE20]
   assign novalid = keep || (sub && ctrl.second_empty); // [RULE15] [RULE19]

   // bit for the current slot; 32-bit words map bit n to slot n unchanged
   always_comb
   begin
      dat = novalid ? 32'h0 : (sub ? cur.right : cur.left); // [RULE19]
      cur_bit = 1'b0;
      if (eff_res == 2'h3 && !novalid)
         cur_bit = dat[slot]; // [RULE1]
      else if (slot <= `DAP_LAST_AUDIO_SLOT)
         cur_bit = dat[5'(slot + 5'h4)];
      else if (slot == `DAP_VALID_SLOT)
         cur_bit = novalid; // [RULE15]
      else if (slot == `DAP_STATUS_SLOT)
         cur_bit = (frame >= `DAP_RATE_CS_FIRST && frame < `DAP_RATE_CS_FIRST + 8'd4) ?
            cs_nib[2'(frame - `DAP_RATE_CS_FIRST)] : 1'b0; // [RULE2] [RULE19]
      else if (slot == `DAP_LAST_SLOT)
         cur_bit = par;
   end

   // even parity over slots 4..30
   always_ff @(posedge sys_clk)
   begin
      if (!resetn || state != DAP_RUN)
         par <= 1'b0;
      else if (tick && half)
      begin
         if (slot < `DAP_FIRST_CODED_SLOT)
            par <= 1'b0;
         else if (slot < `DAP_LAST_SLOT)
            par <= par ^ cur_bit;
      end
   end

   // preamble choice per subframe
   assign preamble = slot < `DAP_FIRST_CODED_SLOT; // [RULE17]
   assign pre_pattern = sub ? `DAP_PRE_W :
      (frame == 8'h0 ? `DAP_PRE_B : `DAP_PRE_M); // [RULE14]

   // line coder; held low whenever the output is disabled
   dap_bmc_coder u_coder
   (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .enable(state == DAP_RUN), // [RULE20]
      .tick(tick),
      .preamble(preamble),
      .pre_pattern(pre_pattern),
      .pre_idx({slot[1:0], half}),
      .half(half),
      .data_bit(cur_bit),
      .line(spdif_out)
   );

   // checks beside the logic they guard
   read_ctrl_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE21]
      addr_ok && !hwrite && haddr[7:0] == `DAP_CTRL_OFS |=> hrdata == 32'(ctrl))
      else $error("control readback wrong");
   div_two_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE13]
      ctrl.bit_clock_internal && ctrl.clk_div == 3'h1 && $stable(ctrl) && tick
      |=> !tick ##1 tick)
      else $error("divide by two spacing wrong");
   block_wrap_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE14]
      state == DAP_RUN && tick && half && sub && slot == 5'd31 && frame == 8'd191
      |=> frame == 8'h0)
      else $error("block did not wrap at 192");
   frame_range_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE14]
      frame < `DAP_BLOCK_FRAMES)
      else $error("frame index out of range");
   slot_step_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE16]
      state == DAP_RUN && tick && half |=> slot == $past(slot) + 5'h1)
      else $error("slot did not advance");
   bmc_first_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE18]
      state == DAP_RUN && tick && !half && !preamble |=> spdif_out != $past(spdif_out))
      else $error("first half state did not invert");
   bmc_second_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE18]
      state == DAP_RUN && tick && half && !preamble
      |=> spdif_out == ($past(spdif_out) ^ $past(cur_bit)))
      else $error("second half state wrong");
   empty_valid_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE15]
      sub && ctrl.second_empty && slot == 5'd28 |-> cur_bit)
      else $error("validity low in empty subframe");
   keep_silent_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE19]
      keep && slot >= 5'd4 && slot <= 5'd27 |-> !cur_bit)
      else $error("audio bit sent in keep-alive");
   off_low_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE20]
      !ctrl.digital_output_enable ##1 !ctrl.digital_output_enable |=> !spdif_out)
      else $error("line not low while disabled");
   dbl_rate_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE6]
      latch_now && ctrl.port1_double_rate |=> cur.left == ($past(hold1.left) & $past(mask)))
      else $error("second port not used");
   stale_set_a: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE4]
      latch_now && state == DAP_RUN && !new_flag |=> stale)
      else $error("stale flag lost");
endmodule : dap_spdif_tx

/* File: dap_optical_rx.sv */
/*
 optical line receiver model: finds preambles, decodes biphase mark bits
 assumes divider code 0 with the internal reference: one state per cycle
*/
`timescale 1ns/100ps
`include "dap_defines.svh"
module dap_optical_rx
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // coded line
   input wire logic line,
   // recovered content
   output logic [27:0] left_bits,
   output logic [27:0] right_bits,
   output logic [191:0] cs_bits,
   output int sub_cnt,
   output int b_sub,
   output int errs
);
   logic [8:0] hist;
   logic [8:0] nh;
   logic [7:0] pre;
   logic [27:0] shift;
   logic [27:0] word;
   logic [7:0] frame;
   logic [5:0] idx;
   logic locked;
   logic is_w;
   // preamble compared relative to the level in front of it
   assign nh = {hist[7:0], line};
   assign pre = nh[7:0] ^ {8{nh[8]}};
   assign word = {nh[1] ^ nh[0], shift[27:1]};
   // only a preamble holds three equal states, so data never fakes one
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         hist <= 9'h000;
         locked <= 1'b0;
         is_w <= 1'b0;
         idx <= 6'h00;
         frame <= 8'h00;
         cs_bits <= '0;
         sub_cnt <= 0;
         b_sub <= 0;
         errs <= 0;
      end
      else
      begin
         hist <= nh;
         if (pre == `DAP_PRE_B || pre == `DAP_PRE_M || pre == `DAP_PRE_W)
         begin
            // first and second subframes must alternate
            if (locked && ((pre == `DAP_PRE_W) == is_w))
               errs <= errs + 1;
            is_w <= (pre == `DAP_PRE_W);
            if (pre == `DAP_PRE_B)
            begin
               frame <= 8'h00;
               b_sub <= sub_cnt;
            end
            else if (pre == `DAP_PRE_M)
               frame <= frame + 8'h01;
            locked <= 1'b1;
            idx <= 6'h00;
         end
         else if (locked)
         begin
            idx <= idx + 6'h01;
            // each bit opens by inverting the state before it
            if (idx[0] && idx < 6'd56)
            begin
               if (nh[1] == nh[2])
                  errs <= errs + 1;
               shift <= word;
            end
            // four preamble slots then 28 coded slots
            if (idx == 6'd55)
            begin
               sub_cnt <= sub_cnt + 1;
               if (is_w)
                  right_bits <= word;
               else
               begin
                  left_bits <= word;
                  cs_bits[frame] <= word[26];
               end
            end
            // no preamble where one is due: lock lost
            if (idx == 6'd63)
            begin
               errs <= errs + 1;
               locked <= 1'b0;
            end
         end
      end
   end
endmodule : dap_optical_rx

/* File: dap_spdif_tx_tb.sv */
/*
 self-checking bench for the pass-through transmitter
 assumes internal reference with divider code 0, so one line state per cycle
*/
`timescale 1ns/100ps
`include "dap_defines.svh"
module dap_spdif_tx_tb;
   import dap_pkg::*;
   typedef struct packed {
      logic [12:0] ctrl;
      logic [10:0] cfg;
      logic [27:0] exp_l;
      logic [27:0] exp_r;
      logic [27:0] mask;
   } dap_row_type;
   localparam logic [31:0] s0 = 32'h1234_5678, s1 = 32'h9abc_def0, s2 = 32'h0f1e_2d3c;
   localparam logic [31:0] s3 = 32'hc3a5_5a3c, p1l = 32'h8421_7bde, p1r = 32'h3579_bdf1;
   localparam logic [31:0] al = 32'h2468_ace0, ar = 32'hfdb9_7531;
   localparam logic [27:0] m = 28'h1ff_ffff, v1 = 28'h100_0000;
   logic sys_clk, resetn, hsel, hwrite, hready, hreadyout, hresp, spdif_out;
   logic port0_valid, port1_valid, alt_valid;
   logic [31:0] haddr, hwdata, hrdata, d;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [3:0][31:0] port0_slots;
   dap_pair_type port1_pair, alt_pair;
   logic [27:0] left_bits, right_bits;
   logic [191:0] cs_bits;
   logic [3:0] nib [8];
   dap_row_type rows [13];
   int sub_cnt, b_sub, errs, bad_count, checks_done, k, x, e0;
   assign hready = hreadyout;
   dap_spdif_tx dut (.sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .serial_bit_clock_in(1'b0), .bus_clock_in(1'b0), .frame_clock_in(1'b0),
      .port0_slots(port0_slots), .port0_valid(port0_valid), .port1_pair(port1_pair),
      .port1_valid(port1_valid), .alt_pair(alt_pair), .alt_valid(alt_valid),
      .spdif_out(spdif_out));
   dap_optical_rx rx (.sys_clk(sys_clk), .resetn(resetn), .line(spdif_out),
      .left_bits(left_bits), .right_bits(right_bits), .cs_bits(cs_bits),
      .sub_cnt(sub_cnt), .b_sub(b_sub), .errs(errs));
   // audio slots for 24, 16 and 20 bit widths, low bits masked
   function automatic logic [27:0] a24(input logic [31:0] s);
      return {4'h0, s[31:8]};
   endfunction : a24
   function automatic logic [27:0] a16(input logic [31:0] s);
      return {4'h0, s[31:16], 8'h00};
   endfunction : a16
   function automatic logic [27:0] a20(input logic [31:0] s);
      return {4'h0, s[31:12], 4'h0};
   endfunction : a20
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // one single transfer; waits on hready in both phases
   task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge sys_clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= wr;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      d = hrdata;
   endtask : ahb
   // output off while settings change, then one sample set, then enable
   task setup(input logic [12:0] ctrl, input logic [10:0] cfg);
      ahb(1'b1, `DAP_CTRL_OFS, {19'h0, ctrl[12:1], 1'b0});
      ahb(1'b1, `DAP_CFG_OFS, {21'h0, cfg});
      @(posedge sys_clk);
      port0_valid <= 1'b1;
      port1_valid <= 1'b1;
      alt_valid <= 1'b1;
      @(posedge sys_clk);
      port0_valid <= 1'b0;
      port1_valid <= 1'b0;
      alt_valid <= 1'b0;
      ahb(1'b1, `DAP_CTRL_OFS, {19'h0, ctrl});
   endtask : setup
   task wait_subs(input int n);
      int s;
      int c;
      s = sub_cnt;
      c = 0;
      while (sub_cnt - s < n && c < 20000)
      begin
         @(posedge sys_clk);
         c++;
      end
   endtask : wait_subs
   task finish_test();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : finish_test
   // 10 MHz clock
   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   // a hung handshake or silent line ends here rather than running forever
   initial
   begin
      #8000000;
      bad_count++;
      $display("watchdog expired");
      finish_test();
   end
   // main sequence
   initial
   begin
      {resetn, hsel, hwrite, port0_valid, port1_valid, alt_valid} = 6'h00;
      haddr = 32'h0;
      hwdata = 32'h0;
      htrans = 2'b00;
      hsize = 3'b010;
      port0_slots = {s3, s2, s1, s0};
      port1_pair = {p1l, p1r};
      alt_pair = {al, ar};
      nib = '{4'hc, 4'h0, 4'h4, 4'h1, 4'h5, 4'h3, 4'h7, 4'h7};
      rows = '{'{13'h0101, 11'h2a4, a24(s0), a24(s1), m},
         '{13'h0101, 11'h2a9, a24(s1), a24(s2), m},
         '{13'h0101, 11'h2ae, a24(s2), a24(s3), m},
         '{13'h0101, 11'h2a3, a24(s3), a24(s0), m},
         '{13'h0111, 11'h2ac, a24(s0), a24(s1), m},
         '{13'h0121, 11'h2a4, a24(p1l), a24(p1r), m},
         '{13'h0109, 11'h2a4, a24(al), a24(ar), m},
         '{13'h0101, 11'h204, a16(s0), a16(s1), m},
         '{13'h0101, 11'h294, a20(s0), a20(s1), m},
         '{13'h0101, 11'h2f4, s0[31:4], s1[31:4], 28'hfff_ffff},
         '{13'h1101, 11'h2a4, a24(s0), v1, m},
         '{13'h0103, 11'h2a4, v1, v1, m},
         '{13'h0107, 11'h2a4, v1, v1, m}};
      repeat (5) @(posedge sys_clk);
      resetn <= 1'b1;
      for (int i = 0; i < 13; i++)
      begin
         setup(rows[i].ctrl, rows[i].cfg);
         wait_subs(4);
         e0 = errs;
         wait_subs(4);
         chk("left slots", rows[i].exp_l, left_bits & rows[i].mask);
         chk("right slots", rows[i].exp_r, right_bits & rows[i].mask);
         chk("coding errors", e0, errs);
         if (rows[i].mask != 28'hfff_ffff)
            chk("parity", 32'h0, {31'h0, ^left_bits});
         $display("row %0d done", i);
      end
      // second reset in mid-run: registers, bus and idle line
      @(posedge sys_clk);
      resetn <= 1'b0;
      repeat (5) @(posedge sys_clk);
      resetn <= 1'b1;
      ahb(1'b0, `DAP_CTRL_OFS, 32'h0);
      chk("ctrl reset", 32'h0000_0002, d);
      ahb(1'b0, `DAP_CFG_OFS, 32'h0);
      chk("cfg reset", 32'h0000_0204, d);
      ahb(1'b1, 8'h10, 32'hffff_ffff);
      ahb(1'b0, 8'h10, 32'h0);
      chk("unmapped read", 32'h0, d);
      chk("response", 32'h0, {31'h0, hresp});
      ahb(1'b1, `DAP_CFG_OFS, 32'hffff_ffff);
      ahb(1'b0, `DAP_CFG_OFS, 32'h0);
      chk("cfg width", 32'h0000_07ff, d);
      ahb(1'b1, `DAP_CTRL_OFS, 32'h0000_0302);
      k = 0;
      repeat (200)
      begin
         @(posedge sys_clk);
         if (spdif_out !== 1'b0)
            k++;
      end
      chk("disabled line", 32'h0, k);
      $display("reset test done");
      // every rate code, nibble in channel status frames 24..27
      for (int r = 0; r < 8; r++)
      begin
         setup(13'h0101, {3'(r), 8'ha4});
         wait_subs(60);
         chk("rate nibble", {28'h0, nib[r]}, {28'h0, cs_bits[27:24]});
      end
      $display("rate test done");
      x = b_sub;
      k = 0;
      while (b_sub == x && k < 30000)
      begin
         @(posedge sys_clk);
         k++;
      end
      chk("block length", 32'd384, b_sub - x);
      $display("block test done");
      finish_test();
   end
endmodule : dap_spdif_tx_tb
